// ===== pkg/clc_pkg.sv
package clc_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADDR_APPLIED = 8'h50;
    localparam logic [7:0] ADDR_CUSTOM = 8'h51;
    localparam logic [7:0] ADDR_PRODUCT = 8'hFD;
    localparam logic [7:0] ADDR_MAKER = 8'hFE;
    localparam logic [7:0] ADDR_REVISION = 8'hFF;
    localparam logic [7:0] RST_APPLIED = 8'h82;
    localparam logic [7:0] RST_CUSTOM = 8'h82;
    // bit 5 is unimplemented and reads zero
    localparam logic [7:0] CFG_MASK = 8'hDF;
    localparam int FLOOR_LSB = 6;
    localparam int R2_LSB = 2;
    // identification values are arbitrary
    localparam logic [7:0] ID_PRODUCT = 8'h3A;
    localparam logic [7:0] ID_MAKER = 8'h17;
    localparam logic [7:0] ID_REVISION = 8'h01;
    localparam logic [7:0] BYTE_INVALID = 8'hFF;

    // ****************************************
    // timing and trip threshold
    // ****************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int BLACKOUT_NS = 5500000;
    localparam int BLACKOUT_CYC = (BLACKOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [11:0] TRIP_FORCE_MA = 12'h690;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX = 5'h02,
        ST_ACK = 5'h04,
        ST_TX = 5'h08,
        ST_TXACK = 5'h10
    } clc_state_e;

    typedef enum logic [1:0] {
        PROF_STANDARD = 2'h0,
        PROF_LEGACY = 2'h1,
        PROF_CUSTOM = 2'h2,
        PROF_NONE = 2'h3
    } clc_profile_e;

    localparam logic [1:0] PH_ADDR = 2'h0;
    localparam logic [1:0] PH_REG = 2'h1;
    localparam logic [1:0] PH_DATA = 2'h2;

    // ****************************************
    // decode functions
    // ****************************************
    function automatic logic [11:0] r2_ma(input logic [2:0] code);
        case (code)
            3'h0: r2_ma = 12'h078;
            3'h1: r2_ma = 12'h23A;
            3'h2: r2_ma = 12'h3E8;
            3'h3: r2_ma = 12'h546;
            3'h4: r2_ma = 12'h690;
            default: r2_ma = 12'h802;
        endcase
    endfunction

    function automatic logic [11:0] floor_mv(input logic [1:0] code);
        case (code)
            2'h0: floor_mv = 12'h5DC;
            2'h1: floor_mv = 12'h6D6;
            2'h2: floor_mv = 12'h7D0;
            default: floor_mv = 12'h8CA;
        endcase
    endfunction

    function automatic logic [11:0] strap_ma(input logic [2:0] step);
        case (step)
            3'h0: strap_ma = 12'h23A;
            3'h1: strap_ma = 12'h3E8;
            3'h2: strap_ma = 12'h46A;
            3'h3: strap_ma = 12'h546;
            3'h4: strap_ma = 12'h690;
            3'h5: strap_ma = 12'h802;
            3'h6: strap_ma = 12'h8E8;
            default: strap_ma = 12'hB22;
        endcase
    endfunction

    localparam logic [11:0] RST_FLOOR_MV = floor_mv(RST_APPLIED[7:6]);
    localparam logic [11:0] RST_HW_MA = strap_ma(3'h0);

endpackage

// ===== logic/clc_ctrl.sv
`timescale 1ns/10ps
module clc_ctrl
    import clc_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h33,
    parameter int BLACKOUT_CYCLES = BLACKOUT_CYC
) (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic HOST_BUS_CLOCK_PIN,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_N,
    input wire logic [3:0] COMM_AND_LIMIT_STRAP,
    input wire logic ASLEEP,
    input wire logic EMU_DONE,
    input wire logic [1:0] EMU_PROFILE,
    input wire logic [7:0] EMU_APPLIED_CFG,
    input wire logic EMU_PROFILE_TRIP,
    output logic WAKE_REQ,
    output logic BUS_MODE,
    output logic [11:0] HW_LIMIT_MA,
    output logic LIMIT_TRIP,
    output logic [1:0] APPLIED_BUS_FLOOR_SEL,
    output logic [2:0] APPLIED_R2_CURRENT_SEL,
    output logic [11:0] BUS_FLOOR_MV
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic scl_s1, scl_s2, scl_s3;
    logic sda_s1, sda_s2, sda_s3;
    logic [3:0] strap_s1, strap_s2;

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_s3 <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_s3 <= 1'b1;
            strap_s1 <= 4'h0;
            strap_s2 <= 4'h0;
        end else begin
            scl_s1 <= HOST_BUS_CLOCK_PIN;
            scl_s2 <= scl_s1;
            scl_s3 <= scl_s2;
            sda_s1 <= SDA_I;
            sda_s2 <= sda_s1;
            sda_s3 <= sda_s2;
            strap_s1 <= COMM_AND_LIMIT_STRAP;
            strap_s2 <= strap_s1;
        end
    end
    logic scl_rise, scl_fall, start_det, stop_det;
    assign scl_rise = scl_s2 & ~scl_s3;
    assign scl_fall = ~scl_s2 & scl_s3;
    assign start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
    assign stop_det = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
    // ****************************************
    // blackout, strap and applied settings
    // ****************************************
    logic [17:0] blk_cnt_r, blk_cnt_nxt;
    logic ready_r, ready_nxt;
    logic [3:0] strap_r, strap_nxt;
    logic bus_mode_r, bus_mode_nxt;
    logic [11:0] hw_ma_r, hw_ma_nxt;
    logic [7:0] applied_r, applied_nxt;
    logic trip_r, trip_nxt;
    logic [11:0] floor_mv_r, floor_mv_nxt;
    logic [7:0] custom_r, custom_nxt;
    logic use_custom;

    assign use_custom = (EMU_PROFILE != PROF_STANDARD);
    always_comb begin
        blk_cnt_nxt = blk_cnt_r;
        ready_nxt = ready_r;
        strap_nxt = strap_r;
        applied_nxt = applied_r;
        trip_nxt = trip_r;
        if (!ready_r) begin
            blk_cnt_nxt = blk_cnt_r + 18'h1;
            strap_nxt = strap_s2;
            if (blk_cnt_r == 18'(BLACKOUT_CYCLES - 1)) begin
                ready_nxt = 1'b1;
            end
        end
        bus_mode_nxt = ~strap_r[3];
        hw_ma_nxt = strap_ma(strap_r[2:0]);
        if (EMU_DONE) begin
            if (use_custom) begin
                applied_nxt = custom_r & CFG_MASK;
                trip_nxt = (r2_ma(custom_r[4:2]) <= hw_ma_r) || (hw_ma_r > TRIP_FORCE_MA);
            end else begin
                applied_nxt = EMU_APPLIED_CFG & CFG_MASK;
                trip_nxt = EMU_PROFILE_TRIP;
            end
        end
        floor_mv_nxt = floor_mv(applied_r[7:6]);
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            blk_cnt_r <= 18'h0;
            ready_r <= 1'b0;
            strap_r <= 4'h0;
            bus_mode_r <= 1'b1;
            hw_ma_r <= RST_HW_MA;
            applied_r <= RST_APPLIED;
            trip_r <= 1'b1;
            floor_mv_r <= RST_FLOOR_MV;
        end else begin
            blk_cnt_r <= blk_cnt_nxt;
            ready_r <= ready_nxt;
            strap_r <= strap_nxt;
            bus_mode_r <= bus_mode_nxt;
            hw_ma_r <= hw_ma_nxt;
            applied_r <= applied_nxt;
            trip_r <= trip_nxt;
            floor_mv_r <= floor_mv_nxt;
        end
    end

    // ****************************************
    // bus client and register file
    // ****************************************
    clc_state_e state_r, state_nxt;
    logic [2:0] bitcnt_r, bitcnt_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [1:0] phase_r, phase_nxt;
    logic rw_r, rw_nxt;
    logic got8_r, got8_nxt;
    logic [7:0] ptr_r, ptr_nxt;
    logic sda_oe_n_r, sda_oe_n_nxt;
    logic wake_txn_r, wake_txn_nxt;
    logic wake_r, wake_nxt;
    logic [7:0] rd_byte;
    always_comb begin
        case (ptr_r)
            ADDR_APPLIED: rd_byte = applied_r;
            ADDR_CUSTOM: rd_byte = custom_r & CFG_MASK;
            ADDR_PRODUCT: rd_byte = ID_PRODUCT;
            ADDR_MAKER: rd_byte = ID_MAKER;
            ADDR_REVISION: rd_byte = ID_REVISION;
            default: rd_byte = 8'h00;
        endcase
        if (wake_txn_r) begin
            rd_byte = BYTE_INVALID;
        end
    end
    always_comb begin
        state_nxt = state_r;
        bitcnt_nxt = bitcnt_r;
        shift_nxt = shift_r;
        phase_nxt = phase_r;
        rw_nxt = rw_r;
        got8_nxt = got8_r;
        ptr_nxt = ptr_r;
        sda_oe_n_nxt = sda_oe_n_r;
        wake_txn_nxt = wake_txn_r;
        wake_nxt = 1'b0;
        custom_nxt = custom_r;
        if (start_det) begin
            state_nxt = ST_RX;
            bitcnt_nxt = 3'h0;
            got8_nxt = 1'b0;
            phase_nxt = PH_ADDR;
            sda_oe_n_nxt = 1'b1;
        end else if (stop_det) begin
            state_nxt = ST_IDLE;
            sda_oe_n_nxt = 1'b1;
            wake_txn_nxt = 1'b0;
        end else begin
            case (state_r)
                ST_RX: begin
                    if (scl_rise) begin
                        shift_nxt = {shift_r[6:0], sda_s2};
                        bitcnt_nxt = bitcnt_r + 3'h1;
                        got8_nxt = (bitcnt_r == 3'h7);
                    end else if (scl_fall && got8_r) begin
                        got8_nxt = 1'b0;
                        state_nxt = ST_ACK;
                        sda_oe_n_nxt = 1'b0;
                        case (phase_r)
                            PH_ADDR: begin
                                rw_nxt = shift_r[0];
                                if (shift_r[7:1] != DEV_ADDR || !ready_r || !bus_mode_r) begin
                                    state_nxt = ST_IDLE;
                                    sda_oe_n_nxt = 1'b1;
                                end else if (ASLEEP && shift_r[0]) begin
                                    wake_nxt = 1'b1;
                                    wake_txn_nxt = 1'b1;
                                end
                            end
                            PH_REG: begin
                                ptr_nxt = shift_r;
                                phase_nxt = PH_DATA;
                            end
                            default: begin
                                if (ptr_r == ADDR_CUSTOM && !ASLEEP && !wake_txn_r) begin
                                    custom_nxt = (shift_r & CFG_MASK) | (custom_r & ~CFG_MASK);
                                end
                                ptr_nxt = ptr_r + 8'h1;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bitcnt_nxt = 3'h0;
                        if (rw_r && phase_r == PH_ADDR) begin
                            state_nxt = ST_TX;
                            shift_nxt = rd_byte;
                            sda_oe_n_nxt = rd_byte[7];
                            phase_nxt = PH_DATA;
                        end else begin
                            state_nxt = ST_RX;
                            sda_oe_n_nxt = 1'b1;
                            if (phase_r == PH_ADDR) begin
                                phase_nxt = PH_REG;
                            end
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bitcnt_r == 3'h7) begin
                            state_nxt = ST_TXACK;
                            sda_oe_n_nxt = 1'b1;
                            ptr_nxt = ptr_r + 8'h1;
                        end else begin
                            shift_nxt = {shift_r[6:0], 1'b0};
                            bitcnt_nxt = bitcnt_r + 3'h1;
                            sda_oe_n_nxt = shift_r[6];
                        end
                    end
                end
                ST_TXACK: begin
                    if (scl_rise) begin
                        if (sda_s2) begin
                            state_nxt = ST_IDLE;
                        end else begin
                            got8_nxt = 1'b1;
                        end
                    end else if (scl_fall && got8_r) begin
                        got8_nxt = 1'b0;
                        state_nxt = ST_TX;
                        bitcnt_nxt = 3'h0;
                        shift_nxt = rd_byte;
                        sda_oe_n_nxt = rd_byte[7];
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                    sda_oe_n_nxt = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            state_r <= ST_IDLE;
            bitcnt_r <= 3'h0;
            shift_r <= 8'h00;
            phase_r <= PH_ADDR;
            rw_r <= 1'b0;
            got8_r <= 1'b0;
            ptr_r <= 8'h00;
            sda_oe_n_r <= 1'b1;
            wake_txn_r <= 1'b0;
            wake_r <= 1'b0;
            custom_r <= RST_CUSTOM;
        end else begin
            state_r <= state_nxt;
            bitcnt_r <= bitcnt_nxt;
            shift_r <= shift_nxt;
            phase_r <= phase_nxt;
            rw_r <= rw_nxt;
            got8_r <= got8_nxt;
            ptr_r <= ptr_nxt;
            sda_oe_n_r <= sda_oe_n_nxt;
            wake_txn_r <= wake_txn_nxt;
            wake_r <= wake_nxt;
            custom_r <= custom_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // clock line has no driver at all: no stretching
    assign SDA_O = 1'b0;
    assign SDA_OE_N = sda_oe_n_r;
    assign WAKE_REQ = wake_r;
    assign BUS_MODE = bus_mode_r;
    assign HW_LIMIT_MA = hw_ma_r;
    assign LIMIT_TRIP = trip_r;
    assign APPLIED_BUS_FLOOR_SEL = applied_r[FLOOR_LSB +: 2];
    assign APPLIED_R2_CURRENT_SEL = applied_r[R2_LSB +: 3];
    assign BUS_FLOOR_MV = floor_mv_r;

    // ****************************************
    // assertions
    // ****************************************
    a_blackout_quiet: assert property (@(posedge MCLK) disable iff (RESET)
        !ready_r |-> sda_oe_n_r && state_r != ST_ACK) else $error("answered in blackout");
    a_blackout_length: assert property (@(posedge MCLK) disable iff (RESET)
        $rose(ready_r) |-> $past(blk_cnt_r) == 18'(BLACKOUT_CYCLES - 1))
        else $error("blackout length wrong");
    a_applied_only_emu: assert property (@(posedge MCLK) disable iff (RESET)
        !EMU_DONE |=> applied_r == $past(applied_r)) else $error("applied changed alone");
    a_applied_reload: assert property (@(posedge MCLK) disable iff (RESET)
        EMU_DONE && use_custom |=> applied_r == ($past(custom_r) & CFG_MASK))
        else $error("applied register not reloaded from custom");
    a_trip_choice: assert property (@(posedge MCLK) disable iff (RESET)
        EMU_DONE && use_custom |=> trip_r == ((r2_ma($past(custom_r[4:2])) <= $past(hw_ma_r))
            || ($past(hw_ma_r) > TRIP_FORCE_MA)))
        else $error("wrong limiting mode chosen");
    a_custom_sleep: assert property (@(posedge MCLK) disable iff (RESET)
        ASLEEP |=> custom_r == $past(custom_r)) else $error("custom changed in sleep");
    a_wake_data: assert property (@(posedge MCLK) disable iff (RESET)
        wake_txn_r && state_r == ST_TX |-> sda_oe_n_r) else $error("wake read drove data");
    a_wake_cause: assert property (@(posedge MCLK) disable iff (RESET)
        wake_r |-> $past(ASLEEP) && wake_txn_r && rw_r ##1 !wake_r) else $error("stray wake");
    a_start_enters: assert property (@(posedge MCLK) disable iff (RESET)
        start_det |=> state_r == ST_RX && phase_r == PH_ADDR && bitcnt_r == 3'h0)
        else $error("start not recognised");
    a_floor_follow: assert property (@(posedge MCLK) disable iff (RESET)
        EMU_DONE |-> ##2 BUS_FLOOR_MV == floor_mv($past(applied_r[7:6])))
        else $error("floor voltage does not follow applied field");
    a_standalone_mute: assert property (@(posedge MCLK) disable iff (RESET)
        !bus_mode_r && state_r == ST_IDLE |=> sda_oe_n_r) else $error("stand-alone answered");

endmodule

// ===== tb/clc_host.sv
`timescale 1ns/10ps
// ****************************************
// bus host model
// ****************************************
module clc_host #(
    parameter logic [6:0] ADDR = 7'h33,
    parameter int SETTLE_CYC = 120000
) (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    int stretch = 0;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic hw(input int n);
        repeat (n) @(negedge clk);
    endtask

    // data falls while the clock is high
    task automatic start_c();
        hw(4);
        sda_low = 1'b0;
        hw(4);
        scl = 1'b1;
        hw(4);
        sda_low = 1'b1;
        hw(4);
        scl = 1'b0;
    endtask

    task automatic stop_c();
        hw(4);
        sda_low = 1'b1;
        hw(4);
        scl = 1'b1;
        hw(4);
        sda_low = 1'b0;
        hw(4);
    endtask

    task automatic bit_c(input logic b, output logic r);
        hw(2);
        sda_low = ~b;
        // low phase may be held longer by the host
        hw(2 + stretch);
        scl = 1'b1;
        hw(4);
        r = sda;
        scl = 1'b0;
    endtask

    task automatic byte_c(input logic [7:0] b, input logic ab, output logic [7:0] r,
                          output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_c(b[i], r[i]);
        end
        bit_c(ab, a);
    endtask

    // unused bits kept as read back, r2 codes 110/111 never sent
    task automatic xfer(input logic [7:0] ra, input logic rd, input logic [7:0] wd,
                        output logic [7:0] rdata, output logic ok);
        logic a0;
        logic a1;
        logic a2;
        logic an;
        logic [7:0] d;
        rdata = 8'h00;
        start_c();
        byte_c({ADDR, 1'b0}, 1'b1, d, a0);
        byte_c(ra, 1'b1, d, a1);
        if (rd) begin
            start_c();
            byte_c({ADDR, 1'b1}, 1'b1, d, a2);
            byte_c(8'hFF, 1'b1, rdata, an);
        end else begin
            byte_c(wd, 1'b1, d, a2);
        end
        stop_c();
        ok = !(a0 | a1 | a2);
    endtask

    // waking read: the host waits after the stop, then the data is returned to the caller
    task automatic wake_read(output logic [7:0] rdata);
        logic a;
        logic [7:0] d;
        start_c();
        byte_c({ADDR, 1'b1}, 1'b1, d, a);
        byte_c(8'hFF, 1'b1, rdata, a);
        stop_c();
        hw(SETTLE_CYC);
    endtask
endmodule

// ===== tb/current_limit_config_and_host_port_bench.sv
`timescale 1ns/10ps
module current_limit_config_and_host_port_bench;
    import clc_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] strap = 4'h4;
    logic asleep = 1'b0;
    logic emu_done = 1'b0;
    logic [1:0] emu_profile = 2'h0;
    logic [7:0] emu_cfg = 8'h00;
    logic emu_trip = 1'b0;
    logic scl;
    logic host_low;
    logic sda;
    logic sda_o;
    logic sda_oe_n;
    logic wake_req;
    logic bus_mode;
    logic [11:0] hw_ma;
    logic trip;
    logic [1:0] fl_sel;
    logic [2:0] r2_sel;
    logic [11:0] fl_mv;
    logic [7:0] rd;
    logic ok;
    int error_cnt = 0;
    int checked = 0;
    int wake_cnt = 0;

    always #12.5 mclk = ~mclk;
    // open-drain data line with pull-up
    assign sda = host_low ? 1'b0 : (sda_oe_n ? 1'b1 : sda_o);
    always @(posedge mclk) if (wake_req === 1'b1) wake_cnt <= wake_cnt + 1;

    clc_ctrl #(.BLACKOUT_CYCLES(200)) dut (
        .MCLK(mclk), .RESET(reset), .HOST_BUS_CLOCK_PIN(scl), .SDA_I(sda),
        .SDA_O(sda_o), .SDA_OE_N(sda_oe_n), .COMM_AND_LIMIT_STRAP(strap),
        .ASLEEP(asleep), .EMU_DONE(emu_done), .EMU_PROFILE(emu_profile),
        .EMU_APPLIED_CFG(emu_cfg), .EMU_PROFILE_TRIP(emu_trip), .WAKE_REQ(wake_req),
        .BUS_MODE(bus_mode), .HW_LIMIT_MA(hw_ma), .LIMIT_TRIP(trip),
        .APPLIED_BUS_FLOOR_SEL(fl_sel), .APPLIED_R2_CURRENT_SEL(r2_sel),
        .BUS_FLOOR_MV(fl_mv)
    );

    clc_host #(.SETTLE_CYC(200)) host (
        .clk(mclk), .sda(sda), .scl(scl), .sda_low(host_low)
    );

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        if (error_cnt == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic do_reset(input logic [3:0] s);
        @(negedge mclk);
        reset = 1'b1;
        strap = s;
        repeat (2) @(negedge mclk);
        reset = 1'b0;
    endtask

    task automatic emu(input logic [1:0] p, input logic [3:0] e_sel, input logic [3:0] e_r2,
                       input logic e_trip, input logic [11:0] e_mv);
        @(negedge mclk);
        emu_done = 1'b1;
        emu_profile = p;
        @(negedge mclk);
        emu_done = 1'b0;
        repeat (3) @(negedge mclk);
        chk({8'h00, 2'h0, fl_sel}, {8'h00, e_sel});
        chk({9'h000, r2_sel}, {8'h00, e_r2});
        chk({11'h000, trip}, {11'h000, e_trip});
        chk(fl_mv, e_mv);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset_and_blackout();
        do_reset(4'h4);
        chk({10'h000, fl_sel}, {10'h000, RST_APPLIED[7:6]});
        chk({9'h000, r2_sel}, 12'h000);
        chk(fl_mv, 12'h7D0);
        host.xfer(ADDR_CUSTOM, 1'b1, 8'h00, rd, ok);
        chk({11'h000, ok}, 12'h000);
        chk({11'h000, bus_mode}, 12'h001);
        chk(hw_ma, 12'h690);
        repeat (250) @(negedge mclk);
    endtask

    task automatic t_registers();
        host.xfer(ADDR_CUSTOM, 1'b1, 8'h00, rd, ok);
        chk({4'h0, rd}, {4'h0, RST_CUSTOM});
        chk({11'h000, ok}, 12'h001);
        host.xfer(ADDR_PRODUCT, 1'b0, 8'h00, rd, ok);
        host.xfer(ADDR_APPLIED, 1'b0, 8'h02, rd, ok);
        host.xfer(ADDR_PRODUCT, 1'b1, 8'h00, rd, ok);
        chk({4'h0, rd}, {4'h0, ID_PRODUCT});
        host.xfer(ADDR_MAKER, 1'b1, 8'h00, rd, ok);
        chk({4'h0, rd}, {4'h0, ID_MAKER});
        host.xfer(ADDR_REVISION, 1'b1, 8'h00, rd, ok);
        chk({4'h0, rd}, {4'h0, ID_REVISION});
        host.xfer(ADDR_APPLIED, 1'b1, 8'h00, rd, ok);
        chk({4'h0, rd}, {4'h0, RST_APPLIED});
        host.xfer(8'h10, 1'b1, 8'h00, rd, ok);
        chk({4'h0, rd}, 12'h000);
    endtask

    task automatic t_emulation();
        emu_cfg = 8'h4C;
        emu_trip = 1'b0;
        emu(2'h0, 4'h1, 4'h3, 1'b0, 12'h6D6);
        host.stretch = 12;
        host.xfer(ADDR_CUSTOM, 1'b0, 8'h96, rd, ok);
        host.stretch = 0;
        chk({11'h000, ok}, 12'h001);
        host.xfer(ADDR_CUSTOM, 1'b1, 8'h00, rd, ok);
        chk({4'h0, rd}, 12'h096);
        for (int p = 1; p < 4; p++) begin
            emu(p[1:0], 4'h2, 4'h5, 1'b0, 12'h7D0);
        end
        host.xfer(ADDR_CUSTOM, 1'b0, 8'hD2, rd, ok);
        emu(2'h3, 4'h3, 4'h4, 1'b1, 12'h8CA);
        host.xfer(ADDR_APPLIED, 1'b1, 8'h00, rd, ok);
        chk({4'h0, rd}, 12'h0D2);
    endtask

    task automatic t_sleep();
        @(negedge mclk);
        asleep = 1'b1;
        host.xfer(ADDR_CUSTOM, 1'b0, 8'h02, rd, ok);
        chk({11'h000, ok}, 12'h001);
        host.wake_read(rd);
        chk({4'h0, rd}, {4'h0, BYTE_INVALID});
        chk(wake_cnt[11:0], 12'h001);
        asleep = 1'b0;
        host.xfer(ADDR_CUSTOM, 1'b1, 8'h00, rd, ok);
        chk({4'h0, rd}, 12'h0D2);
    endtask

    task automatic t_standalone();
        do_reset(4'hB);
        repeat (250) @(negedge mclk);
        chk({11'h000, bus_mode}, 12'h000);
        chk(hw_ma, 12'h546);
        host.xfer(ADDR_CUSTOM, 1'b1, 8'h00, rd, ok);
        chk({11'h000, ok}, 12'h000);
    endtask

    initial begin
        #2000000;
        error_cnt++;
        end_of_test();
    end

    initial begin
        t_reset_and_blackout();
        t_registers();
        t_emulation();
        t_sleep();
        t_standalone();
        end_of_test();
    end
endmodule
